//--- pkg/qsd_pkg.sv
package qsd_pkg;
    localparam int NUM_CH = 4;
    localparam int FRAME_BITS = 8;
    localparam int CLK_MHZ = 25;
    // fault filter time in microseconds, typical figure
    localparam int FAULT_FILTER_US = 110;
    localparam int FAULT_FILTER_CYC = FAULT_FILTER_US * CLK_MHZ;
    // frame layout: command in the top bits, data in the low nibble
    localparam int CMD_POS = 6;
    localparam int CMD_W = 2;
    localparam int DATA_POS = 0;
    localparam int DATA_W = 4;
    localparam int PAGE_POS = 0;
    localparam logic [1:0] CMD_DIAG = 2'h0;
    localparam logic [1:0] CMD_WR_OR = 2'h1;
    localparam logic [1:0] CMD_WR_AND = 2'h2;
    localparam logic [1:0] CMD_SLEEP = 2'h3;
    // reset values
    localparam logic [3:0] RST_SERIAL_ON = 4'h0;
    localparam logic RST_COMBINE_AND = 1'b0;
    localparam logic RST_PAGE = 1'b0;
    localparam logic [3:0] RST_FLAGS = 4'h0;
endpackage : qsd_pkg

//--- core/qsd_fault_filter.sv
`timescale 1ns/1ps
module qsd_fault_filter import qsd_pkg::*; #(
    parameter int FILTER_CYC = FAULT_FILTER_CYC
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic raw,
    output logic filt
);
    localparam int CW = $clog2(FILTER_CYC + 1);
    localparam logic [CW-1:0] CNT_TOP = CW'(FILTER_CYC);

    generate
        if (FILTER_CYC < 1) begin : g_bad
            $error("qsd_fault_filter: FILTER_CYC must be at least 1");
        end
    endgenerate

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic filt;
    } qsd_filt_state_type;

    qsd_filt_state_type st_ff;
    qsd_filt_state_type nxt_st;

    // fault seen only once it outlasts the filter time
    always_comb begin
        nxt_st = st_ff;
        if (!raw) begin
            nxt_st.cnt = '0;
            nxt_st.filt = 1'b0;
        end else if (st_ff.cnt == CNT_TOP) begin
            nxt_st.filt = 1'b1;
        end else begin
            nxt_st.cnt = st_ff.cnt + CW'(1);
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '0;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    assign filt = st_ff.filt;
endmodule : qsd_fault_filter

//--- core/qsd_spi_shift.sv
`timescale 1ns/1ps
module qsd_spi_shift import qsd_pkg::*; (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic cs_fall,
    input wire logic cs_rise,
    input wire logic sclk_rise,
    input wire logic sclk_fall,
    input wire logic si_bit,
    input wire logic [FRAME_BITS-1:0] load_data,
    output logic so_bit,
    output logic frame_ok,
    output logic [FRAME_BITS-1:0] rx_data
);
    localparam int BW = $clog2(FRAME_BITS);

    typedef struct packed {
        logic [FRAME_BITS-1:0] sr;
        logic [BW-1:0] cnt;
        logic any_byte;
        logic so;
    } qsd_shift_state_type;

    qsd_shift_state_type st_ff;
    qsd_shift_state_type nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (cs_fall) begin
            nxt_st.sr = load_data;
            nxt_st.so = load_data[FRAME_BITS-1];
            nxt_st.cnt = '0;
            nxt_st.any_byte = 1'b0;
        end else begin
            if (sclk_rise) begin
                nxt_st.so = st_ff.sr[FRAME_BITS-1];
            end
            if (sclk_fall) begin
                nxt_st.sr = {st_ff.sr[FRAME_BITS-2:0], si_bit};
                nxt_st.cnt = st_ff.cnt + BW'(1);
                if (st_ff.cnt == BW'(FRAME_BITS - 1)) begin
                    nxt_st.any_byte = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '0;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    // accepted only on a whole, nonzero number of bytes
    assign frame_ok = cs_rise && st_ff.any_byte && (st_ff.cnt == '0);
    assign rx_data = st_ff.sr;
    assign so_bit = st_ff.so;
endmodule : qsd_spi_shift

//--- core/qsd_top.sv
`timescale 1ns/1ps
module qsd_top import qsd_pkg::*; #(
    parameter int CH = NUM_CH,
    parameter int FILTER_CYC = FAULT_FILTER_CYC
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic reset_pin_n,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic si,
    output logic so_out,
    output logic so_oe,
    input wire logic input_polarity_select,
    input wire logic [CH-1:0] channel_input_pin,
    input wire logic [CH-1:0] overload_det,
    input wire logic [CH-1:0] overtemp_det,
    input wire logic [CH-1:0] cooled_det,
    input wire logic [CH-1:0] open_load_det,
    input wire logic [CH-1:0] short_ground_det,
    output logic [CH-1:0] channel_on,
    output logic [CH-1:0] current_limit,
    output logic [CH-1:0] overload_flag,
    output logic [CH-1:0] overtemp_flag,
    output logic [CH-1:0] protection_flag,
    output logic [CH-1:0] open_load_flag,
    output logic [CH-1:0] short_ground_flag,
    output logic [CH-1:0] channel_serial_on_bit,
    output logic logic_combine_select,
    output logic sleep_mode
);
    // five single pins followed by six channel groups
    localparam int SW = 5 + 6 * CH;
    // chip select and reset pin idle high, every other pin idles low
    localparam logic [SW-1:0] SYNC_IDLE = {1'b1, 3'h0, 1'b1, {(6 * CH){1'b0}}};

    generate
        if (CH != DATA_W) begin : g_bad_ch
            $error("qsd_top: CH must match the frame data width");
        end
        if (FILTER_CYC < 1) begin : g_bad_filt
            $error("qsd_top: FILTER_CYC must be at least 1");
        end
        if (FRAME_BITS != 2 * CH) begin : g_bad_frame
            $error("qsd_top: diagnosis byte must hold two channel groups");
        end
        if (CMD_POS + CMD_W > FRAME_BITS) begin : g_bad_cmd
            $error("qsd_top: command field must fit the frame");
        end
    endgenerate

    typedef struct packed {
        logic [SW-1:0] s1;
        logic [SW-1:0] s2;
        logic cs_prev;
        logic sclk_prev;
        logic [CH-1:0] serial_on;
        logic combine_and;
        logic page;
        logic sleep;
        logic [CH-1:0] ot_shut;
        logic [CH-1:0] ovl;
        logic [CH-1:0] ovt;
        logic [CH-1:0] opn;
        logic [CH-1:0] sgd;
        logic [CH-1:0] on;
        logic [CH-1:0] ilim;
        logic [CH-1:0] prot;
    } qsd_top_state_type;

    qsd_top_state_type st_ff;
    qsd_top_state_type nxt_st;

    // synchronised copies
    logic cs_s;
    logic sclk_s;
    logic si_s;
    logic prg_s;
    logic rpin_s;
    logic [CH-1:0] in_s;
    logic [CH-1:0] ovl_s;
    logic [CH-1:0] ovt_s;
    logic [CH-1:0] cool_s;
    logic [CH-1:0] opn_s;
    logic [CH-1:0] sgd_s;
    logic [SW-1:0] raw_pins;

    assign raw_pins = {cs_n, sclk, si, input_polarity_select, reset_pin_n,
                       channel_input_pin, overload_det, overtemp_det, cooled_det,
                       open_load_det, short_ground_det};
    assign {cs_s, sclk_s, si_s, prg_s, rpin_s, in_s, ovl_s, ovt_s, cool_s, opn_s, sgd_s}
        = st_ff.s2;

    // edge finding; clock edges only count while selected
    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;
    assign cs_fall = st_ff.cs_prev && !cs_s;
    assign cs_rise = !st_ff.cs_prev && cs_s;
    assign sclk_rise = sclk_s && !st_ff.sclk_prev && !cs_s && !st_ff.cs_prev;
    assign sclk_fall = !sclk_s && st_ff.sclk_prev && !cs_s && !st_ff.cs_prev;

    // filtered faults
    logic [CH-1:0] ovl_f;
    logic [CH-1:0] opn_f;
    logic [CH-1:0] sgd_f;
    genvar gi;
    generate
        for (gi = 0; gi < CH; gi++) begin : g_filt
            qsd_fault_filter #(.FILTER_CYC(FILTER_CYC)) u_ovl (
                .ref_clk(ref_clk),
                .reset_n(reset_n),
                .ce(ce),
                .raw(ovl_s[gi]),
                .filt(ovl_f[gi])
            );
            qsd_fault_filter #(.FILTER_CYC(FILTER_CYC)) u_opn (
                .ref_clk(ref_clk),
                .reset_n(reset_n),
                .ce(ce),
                .raw(opn_s[gi]),
                .filt(opn_f[gi])
            );
            qsd_fault_filter #(.FILTER_CYC(FILTER_CYC)) u_sgd (
                .ref_clk(ref_clk),
                .reset_n(reset_n),
                .ce(ce),
                .raw(sgd_s[gi]),
                .filt(sgd_f[gi])
            );
        end
    endgenerate

    // diagnosis byte picked by the last page request
    function automatic logic [FRAME_BITS-1:0] diag_byte(input qsd_top_state_type s);
        logic [CH-1:0] prot;
        prot = s.ovl | s.ovt;
        if (s.page) begin
            diag_byte = {s.sgd, s.serial_on};
        end else begin
            diag_byte = {prot, s.opn};
        end
    endfunction : diag_byte

    logic frame_ok;
    logic [FRAME_BITS-1:0] rx_data;
    logic so_bit;

    qsd_spi_shift u_shift (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .ce(ce),
        .cs_fall(cs_fall),
        .cs_rise(cs_rise),
        .sclk_rise(sclk_rise),
        .sclk_fall(sclk_fall),
        .si_bit(si_s),
        .load_data(diag_byte(st_ff)),
        .so_bit(so_bit),
        .frame_ok(frame_ok),
        .rx_data(rx_data)
    );

    // command and data fields of the received byte
    logic [CMD_W-1:0] cmd;
    logic [DATA_W-1:0] cmd_data;
    logic [CH-1:0] pin_act;
    logic [CH-1:0] want_on;
    assign cmd = rx_data[CMD_POS +: CMD_W];
    assign cmd_data = rx_data[DATA_POS +: DATA_W];
    assign pin_act = prg_s ? in_s : ~in_s;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = raw_pins;
        nxt_st.s2 = st_ff.s1;
        nxt_st.cs_prev = cs_s;
        nxt_st.sclk_prev = sclk_s;
        // set wins over clear except on a sleep frame or reset pin low: sticky bits keep live faults
        if (frame_ok) begin
            nxt_st.ovl = RST_FLAGS;
            nxt_st.ovt = RST_FLAGS;
            nxt_st.opn = RST_FLAGS;
            nxt_st.sgd = RST_FLAGS;
        end
        nxt_st.ovl = nxt_st.ovl | ovl_f;
        nxt_st.ovt = nxt_st.ovt | ovt_s;
        nxt_st.opn = nxt_st.opn | opn_f;
        nxt_st.sgd = nxt_st.sgd | sgd_f;
        // thermal shutdown holds until cooled
        for (int i = 0; i < CH; i++) begin
            if (ovt_s[i]) begin
                nxt_st.ot_shut[i] = 1'b1;
            end else if (cool_s[i]) begin
                nxt_st.ot_shut[i] = 1'b0;
            end
        end
        if (frame_ok) begin
            // any good frame other than sleep wakes the device
            nxt_st.sleep = 1'b0;
            // command sits in the last byte shifted in
            unique case (cmd)
                CMD_DIAG: begin
                    nxt_st.page = cmd_data[PAGE_POS];
                end
                CMD_WR_OR: begin
                    nxt_st.serial_on = cmd_data;
                    nxt_st.combine_and = 1'b0;
                end
                CMD_WR_AND: begin
                    nxt_st.serial_on = cmd_data;
                    nxt_st.combine_and = 1'b1;
                end
                CMD_SLEEP: begin
                    nxt_st.sleep = 1'b1;
                    nxt_st.serial_on = RST_SERIAL_ON;
                    nxt_st.combine_and = RST_COMBINE_AND;
                    nxt_st.page = RST_PAGE;
                    nxt_st.ovl = RST_FLAGS;
                    nxt_st.ovt = RST_FLAGS;
                    nxt_st.opn = RST_FLAGS;
                    nxt_st.sgd = RST_FLAGS;
                    nxt_st.ot_shut = RST_FLAGS;
                end
            endcase
        end
        // reset pin low overrides any frame taken in the same cycle
        if (!rpin_s) begin
            nxt_st.sleep = 1'b1;
            nxt_st.serial_on = RST_SERIAL_ON;
            nxt_st.combine_and = RST_COMBINE_AND;
            nxt_st.page = RST_PAGE;
            nxt_st.ovl = RST_FLAGS;
            nxt_st.ovt = RST_FLAGS;
            nxt_st.opn = RST_FLAGS;
            nxt_st.sgd = RST_FLAGS;
            nxt_st.ot_shut = RST_FLAGS;
        end
        // drive from pin and serial bit; thermal shutdown and sleep force off
        want_on = nxt_st.combine_and ? (pin_act & nxt_st.serial_on)
                                     : (pin_act | nxt_st.serial_on);
        nxt_st.on = want_on & ~nxt_st.ot_shut & ~ovt_s & {CH{!nxt_st.sleep}};
        nxt_st.ilim = nxt_st.on & ovl_s;
        nxt_st.prot = nxt_st.ovl | nxt_st.ovt;
    end

    // synchronisers leave reset at the pins' idle levels, so no false fault
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '0;
            st_ff.s1 <= SYNC_IDLE;
            st_ff.s2 <= SYNC_IDLE;
            st_ff.cs_prev <= 1'b1;
            st_ff.sclk_prev <= 1'b0;
            st_ff.sleep <= 1'b1;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    assign so_out = so_bit;
    // serial out released until the second selected cycle
    assign so_oe = !cs_s && !st_ff.cs_prev;
    assign channel_on = st_ff.on;
    assign current_limit = st_ff.ilim;
    assign overload_flag = st_ff.ovl;
    assign overtemp_flag = st_ff.ovt;
    assign protection_flag = st_ff.prot;
    assign open_load_flag = st_ff.opn;
    assign short_ground_flag = st_ff.sgd;
    assign channel_serial_on_bit = st_ff.serial_on;
    assign logic_combine_select = st_ff.combine_and;
    assign sleep_mode = st_ff.sleep;
endmodule : qsd_top

//--- test/qsd_top_checker.sv
`timescale 1ns/1ps
module qsd_top_checker import qsd_pkg::*; #(
    parameter int CH = NUM_CH,
    parameter int FILTER_CYC = FAULT_FILTER_CYC
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic reset_pin_n,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic so_out,
    input wire logic so_oe,
    input wire logic [CH-1:0] overload_det,
    input wire logic [CH-1:0] overtemp_det,
    input wire logic [CH-1:0] channel_on,
    input wire logic [CH-1:0] overload_flag,
    input wire logic [CH-1:0] overtemp_flag,
    input wire logic [CH-1:0] protection_flag,
    input wire logic [CH-1:0] open_load_flag,
    input wire logic [CH-1:0] channel_serial_on_bit,
    input wire logic logic_combine_select,
    input wire logic sleep_mode
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    typedef struct packed {
        logic [15:0] run;
    } qsd_chk_type;
    qsd_chk_type st_ff, nxt_st;
    // length of the current overload run on channel 0
    always_comb begin
        nxt_st.run = 16'h0000;
        if (overload_det[0]) begin
            nxt_st.run = (st_ff.run == 16'hFFFF) ? st_ff.run : st_ff.run + 16'h0001;
        end
    end
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
    property p_prot; protection_flag == (overload_flag | overtemp_flag); endproperty
    a_prot: assert property (p_prot) else $error("protection flag mismatch");
    property p_filt_min; $rose(overload_flag[0]) |-> $past(st_ff.run, 4) >= 16'(FILTER_CYC / 2);
    endproperty
    a_filt_min: assert property (p_filt_min) else $error("overload flag too early");
    property p_filt_max;
        (st_ff.run == 16'(FILTER_CYC + 8)) && reset_pin_n |-> overload_flag[0];
    endproperty
    a_filt_max: assert property (p_filt_max) else $error("overload flag missing");
    property p_ot; (overtemp_det[0] && reset_pin_n)[*6] |-> overtemp_flag[0] && !channel_on[0];
    endproperty
    a_ot: assert property (p_ot) else $error("thermal shutdown late");
    property p_so_idle; cs_n[*4] |-> !so_oe; endproperty
    a_so_idle: assert property (p_so_idle) else $error("serial out driven while idle");
    property p_so_on; $fell(cs_n) ##1 !cs_n[*5] |-> so_oe; endproperty
    a_so_on: assert property (p_so_on) else $error("serial out not enabled");
    property p_so_shift; so_oe && $past(so_oe) && $changed(so_out) |-> $past(sclk, 2); endproperty
    a_so_shift: assert property (p_so_shift) else $error("serial out moved off clock");
    property p_clr;
        $fell(overload_flag[0] | open_load_flag[0] | overtemp_flag[0])
            |-> $past(cs_n, 2) || !$past(reset_pin_n, 2);
    endproperty
    a_clr: assert property (p_clr) else $error("flag cleared outside frame end");
    property p_sleep; sleep_mode && $past(sleep_mode) |-> channel_on == '0; endproperty
    a_sleep: assert property (p_sleep) else $error("channel on in sleep");
    property p_pin;
        !reset_pin_n[*4] |-> sleep_mode && !logic_combine_select
            && channel_serial_on_bit == '0 && overload_flag == '0;
    endproperty
    a_pin: assert property (p_pin) else $error("reset pin defaults wrong");
    c_clr: cover property ($fell(overload_flag[0]));
    c_ot: cover property ($rose(overtemp_flag[0]));
    c_wake: cover property ($fell(sleep_mode));
endmodule : qsd_top_checker
bind qsd_top qsd_top_checker #(.CH(CH), .FILTER_CYC(FILTER_CYC)) u_chk (
    .ref_clk, .reset_n, .reset_pin_n, .cs_n, .sclk, .so_out, .so_oe, .overload_det,
    .overtemp_det, .channel_on, .overload_flag, .overtemp_flag, .protection_flag,
    .open_load_flag, .channel_serial_on_bit, .logic_combine_select, .sleep_mode
);

//--- test/qsd_spi_master.sv
`timescale 1ns/1ps
module qsd_spi_master (
    input wire logic ref_clk,
    input wire logic so_line,
    output logic cs_n,
    output logic sclk,
    output logic si
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        si = 1'b0;
    end
    task automatic gap(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : gap
    // shifts d[n-1:0] out msb first, collects serial out
    task automatic xfer(input logic [15:0] d, input int n, output logic [15:0] q);
        q = 16'h0000;
        cs_n = 1'b0;
        gap(4);
        for (int i = n - 1; i >= 0; i--) begin
            si = d[i];
            sclk = 1'b1;
            gap(4);
            sclk = 1'b0;
            gap(4);
            q = {q[14:0], so_line};
        end
        cs_n = 1'b1;
        si = 1'b0;
        gap(8);
    endtask : xfer
endmodule : qsd_spi_master

//--- test/test_qsd_top.sv
`timescale 1ns/1ps
module test_qsd_top import qsd_pkg::*;;
    localparam int FILT = 20;
    logic ref_clk, reset_n, ce, reset_pin_n, cs_n, sclk, si, so_out, so_oe;
    logic input_polarity_select, logic_combine_select, sleep_mode;
    logic [3:0] channel_input_pin, overload_det, overtemp_det, cooled_det, open_load_det;
    logic [3:0] short_ground_det, channel_on, current_limit, overload_flag, overtemp_flag;
    logic [3:0] protection_flag, open_load_flag, short_ground_flag, channel_serial_on_bit;
    int mismatches = 0;
    int n_tests = 0;
    wire so_w = so_oe ? so_out : 1'bz;
    qsd_top #(.CH(4), .FILTER_CYC(FILT)) DUT (
        .ref_clk, .reset_n, .ce, .reset_pin_n, .cs_n, .sclk, .si, .so_out, .so_oe,
        .input_polarity_select, .channel_input_pin, .overload_det, .overtemp_det,
        .cooled_det, .open_load_det, .short_ground_det, .channel_on, .current_limit,
        .overload_flag, .overtemp_flag, .protection_flag, .open_load_flag,
        .short_ground_flag, .channel_serial_on_bit, .logic_combine_select, .sleep_mode
    );
    qsd_spi_master u_master (.ref_clk, .so_line(so_w), .cs_n, .sclk, .si);
    task automatic gap(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : gap
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    function automatic logic [7:0] fr(input logic [1:0] c, input logic [3:0] d);
        return {c, 2'b00, d};
    endfunction : fr
    function automatic logic [15:0] st();
        return {5'h00, so_oe, sleep_mode, logic_combine_select, channel_serial_on_bit, channel_on};
    endfunction : st
    function automatic logic [15:0] fl();
        return {overload_flag, overtemp_flag, open_load_flag, short_ground_flag};
    endfunction : fl
    task automatic t_logic();
        logic [15:0] q;
        u_master.xfer({8'h00, fr(CMD_WR_OR, 4'h5)}, 8, q);
        chk("or", st(), 16'h0057);
        input_polarity_select = 1'b0;
        gap(6);
        chk("pol", st(), 16'h005D);
        u_master.xfer({8'h00, fr(CMD_WR_AND, 4'h5)}, 8, q);
        chk("and", st(), 16'h0154);
        input_polarity_select = 1'b1;
        gap(6);
        chk("and1", st(), 16'h0151);
    endtask : t_logic
    task automatic t_faults();
        logic [15:0] q;
        overload_det = 4'h1;
        gap(FILT / 2);
        overload_det = 4'h0;
        gap(FILT);
        chk("glitch", overload_flag, 4'h0);
        overload_det = 4'h1;
        open_load_det = 4'h4;
        short_ground_det = 4'h8;
        gap(FILT + 10);
        chk("flags", {current_limit, overload_flag, open_load_flag, short_ground_flag},
            16'h1148);
        overload_det = 4'h0;
        open_load_det = 4'h0;
        gap(6);
        u_master.xfer(16'h001F, 5, q);
        chk("part", {sleep_mode, overload_flag}, 16'h0001);
        u_master.xfer({8'h00, fr(CMD_DIAG, 4'h1)}, 8, q);
        chk("pg0", q, 16'h0014);
        chk("clr", {overload_flag, open_load_flag, short_ground_flag}, 16'h0008);
        short_ground_det = 4'h0;
        gap(6);
        u_master.xfer({8'h00, fr(CMD_DIAG, 4'h0)}, 8, q);
        chk("pg1", q, 16'h0085);
        chk("clr1", short_ground_flag, 4'h0);
    endtask : t_faults
    task automatic t_ot();
        logic [15:0] q;
        overtemp_det = 4'h1;
        cooled_det = 4'hE;
        gap(6);
        chk("ot", {channel_on[0], overtemp_flag[0], protection_flag[0]}, 16'h0003);
        overtemp_det = 4'h0;
        gap(6);
        chk("hyst", channel_on[0], 1'b0);
        cooled_det = 4'hF;
        gap(6);
        chk("cool", {channel_on[0], overtemp_flag[0]}, 16'h0003);
        u_master.xfer({8'h00, fr(CMD_DIAG, 4'h0)}, 8, q);
        chk("otrd", q, 16'h0010);
        chk("otclr", overtemp_flag, 4'h0);
    endtask : t_ot
    task automatic t_chain();
        logic [15:0] q;
        u_master.xfer({fr(CMD_WR_OR, 4'hF), fr(CMD_WR_OR, 4'h6)}, 16, q);
        chk("chain", q, 16'h004F);
        chk("chst", st(), 16'h0067);
    endtask : t_chain
    task automatic t_sleep();
        logic [15:0] q;
        u_master.xfer({8'h00, fr(CMD_SLEEP, 4'h0)}, 8, q);
        chk("slp", st(), 16'h0200);
        u_master.xfer({8'h00, fr(CMD_WR_AND, 4'h3)}, 8, q);
        chk("wake", st(), 16'h0133);
        reset_pin_n = 1'b0;
        gap(6);
        chk("pin", st(), 16'h0200);
        reset_pin_n = 1'b1;
        gap(6);
    endtask : t_sleep
    task automatic t_ce();
        ce = 1'b0;
        overtemp_det = 4'h2;
        gap(6);
        chk("frz", overtemp_flag, 4'h0);
        ce = 1'b1;
        gap(6);
        chk("thaw", overtemp_flag, 4'h2);
        overtemp_det = 4'h0;
        reset_n = 1'b0;
        gap(2);
        reset_n = 1'b1;
        gap(6);
        chk("rst2", st(), 16'h0200);
        chk("rst2f", fl(), 16'h0000);
    endtask : t_ce
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        end_sim();
    end
    initial begin
        reset_n = 1'b0;
        ce = 1'b1;
        reset_pin_n = 1'b1;
        input_polarity_select = 1'b1;
        channel_input_pin = 4'h3;
        overload_det = 4'h0;
        overtemp_det = 4'h0;
        cooled_det = 4'hF;
        open_load_det = 4'h0;
        short_ground_det = 4'h0;
        gap(8);
        reset_n = 1'b1;
        gap(6);
        chk("rst", st(), 16'h0200);
        chk("rstf", fl(), 16'h0000);
        t_logic();
        t_faults();
        t_ot();
        t_chain();
        t_sleep();
        t_ce();
        end_sim();
    end
endmodule : test_qsd_top
